//--- core/shadow_remap_memory_decoder.sv
// memory decoder: shadow layouts, upper memory relocation, wait states, AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module shadow_remap_memory_decoder #(
  parameter bit EXT_CACHE = 1'b1
) (
  input wire logic clk_sys_i, // 20 MHz system clock
  input wire logic resetn_i, // synchronous reset, active low
  input wire logic [4:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [4:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic acc_req_i, // host access request pulse
  input wire logic [23:0] acc_addr_i, // host byte address
  input wire logic acc_we_i, // host access is a write
  output logic acc_busy_o, // access in progress
  output logic acc_done_o, // access finished pulse
  output logic dram_cyc_o, // access goes to on-board DRAM
  output logic [23:0] dram_addr_o, // DRAM address after relocation
  output logic cacheable_o, // read may be cached
  output logic offboard_cycle_n_o, // off-board cycle, active low
  input wire logic cache_size_select_i, // static strap, high for 64KB
  output logic ext_cache_64k_o // external cache runs as 64KB
);
  function automatic logic mapped(input logic [4:0] a);
    mapped = (a == shadow_remap_pkg::OFS_CTRL) || (a == shadow_remap_pkg::OFS_WAIT) ||
             (a == shadow_remap_pkg::OFS_MEM) || (a == shadow_remap_pkg::OFS_STAT);
  endfunction

  function automatic logic [4:0] mem_mb(input logic [2:0] cfg);
    unique case (cfg)
      3'h0: mem_mb = 5'h00;
      3'h1: mem_mb = 5'h01;
      3'h2: mem_mb = 5'h02;
      3'h3: mem_mb = 5'h04;
      3'h4: mem_mb = 5'h05;
      3'h5: mem_mb = 5'h08;
      3'h6: mem_mb = 5'h0C;
      3'h7: mem_mb = 5'h10;
    endcase
  endfunction

  logic [3:0] ctrl, next_ctrl;
  logic [2:0] wait_cfg, next_wait_cfg;
  logic [2:0] mem_cfg, next_mem_cfg;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [4:0] awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, stat_word;
  logic cs_meta, cs_sync, next_ext64;
  logic [1:0] layout;
  logic shadow_en, wr_en;
  logic [4:0] top_mb;
  logic [3:0] remap_units;
  logic [24:0] top, a25, roff;
  logic in_bios, in_vid, shadow_hit, in_remap, in_low;
  logic [6:0] ext_kb;

  assign layout = ctrl[shadow_remap_pkg::CTRL_LAYOUT_LSB +: 2];
  assign shadow_en = ctrl[shadow_remap_pkg::CTRL_SHADOW_EN];
  assign wr_en = ctrl[shadow_remap_pkg::CTRL_WR_EN];
  assign top_mb = mem_mb(mem_cfg);
  assign top = {top_mb, 20'h00000};
  assign a25 = {1'b0, acc_addr_i};
  assign roff = a25 - top;

  always_comb begin
    remap_units = 4'h0;
    if (shadow_en) begin
      remap_units = (layout == 2'h3) ? 4'h0 : shadow_remap_pkg::UNITS_256K;
    end else if (mem_cfg == 3'h1 || mem_cfg == 3'h2) begin
      remap_units = shadow_remap_pkg::UNITS_384K;
    end else if (mem_cfg == 3'h3) begin
      remap_units = shadow_remap_pkg::UNITS_256K;
    end
  end

  // bit 0 of layout selects 128K system firmware, bit 1 adds display firmware
  assign in_bios = acc_addr_i < shadow_remap_pkg::MB1 && acc_addr_i >= (layout[0] ?
                   shadow_remap_pkg::BIOS128_BASE : shadow_remap_pkg::BIOS64_BASE);
  assign in_vid = layout[1] && acc_addr_i >= shadow_remap_pkg::VID_BASE &&
                  acc_addr_i < (layout[0] ? shadow_remap_pkg::BIOS128_BASE :
                  shadow_remap_pkg::VID64_END);
  assign shadow_hit = shadow_en && (in_bios || in_vid);
  // relocated window sits right above installed memory, kept between 1MB and 16MB
  assign in_remap = remap_units != 4'h0 && a25 >= top &&
                    a25 >= {1'h0, shadow_remap_pkg::MB1} &&
                    a25 < shadow_remap_pkg::MB16 &&
                    a25 < top + {5'h00, remap_units, 16'h0000};
  assign in_low = a25 < top && (acc_addr_i < shadow_remap_pkg::UMA_BASE ||
                  acc_addr_i >= shadow_remap_pkg::MB1);
  assign ext_kb = ext_cache_64k_o ? shadow_remap_pkg::EXT_KB_64 :
                  (EXT_CACHE ? shadow_remap_pkg::EXT_KB_32 : 7'h00);
  assign stat_word = (32'(shadow_remap_pkg::INT_CACHE_BYTES) << shadow_remap_pkg::STAT_INT_LSB) |
                     (32'(ext_kb) << shadow_remap_pkg::STAT_EXT_LSB) |
                     (32'(remap_units) << shadow_remap_pkg::STAT_REMAP_LSB) |
                     (32'(top_mb) << shadow_remap_pkg::STAT_MEM_LSB);

  // register slave
  always_comb begin
    next_ctrl = ctrl;
    next_wait_cfg = wait_cfg;
    next_mem_cfg = mem_cfg;
    next_aw_held = aw_held;
    next_awaddr = awaddr;
    next_w_held = w_held;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = s_axi_bvalid_o;
    next_bresp = s_axi_bresp_o;
    next_rvalid = s_axi_rvalid_o;
    next_rresp = s_axi_rresp_o;
    next_rdata = s_axi_rdata_o;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_wdata = s_axi_wdata_i;
      next_wstrb = s_axi_wstrb_i;
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid_o) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(awaddr) ? shadow_remap_pkg::RESP_OKAY : shadow_remap_pkg::RESP_SLVERR;
      if (wstrb[0]) begin
        case (awaddr)
          shadow_remap_pkg::OFS_CTRL: next_ctrl = wdata[3:0];
          shadow_remap_pkg::OFS_WAIT: next_wait_cfg = wdata[2:0];
          shadow_remap_pkg::OFS_MEM: next_mem_cfg = wdata[2:0];
          default: ;
        endcase
      end
    end
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr_i) ? shadow_remap_pkg::RESP_OKAY :
                   shadow_remap_pkg::RESP_SLVERR;
      case (s_axi_araddr_i)
        shadow_remap_pkg::OFS_CTRL: next_rdata = {28'h0000000, ctrl};
        shadow_remap_pkg::OFS_WAIT: next_rdata = {29'h00000000, wait_cfg};
        shadow_remap_pkg::OFS_MEM: next_rdata = {29'h00000000, mem_cfg};
        shadow_remap_pkg::OFS_STAT: next_rdata = stat_word;
        default: next_rdata = 32'h00000000;
      endcase
    end
    next_ext64 = EXT_CACHE && cs_sync;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ctrl <= shadow_remap_pkg::CTRL_RST;
      wait_cfg <= shadow_remap_pkg::WAIT_RST;
      mem_cfg <= shadow_remap_pkg::MEM_RST;
      aw_held <= 1'b0;
      awaddr <= 5'h00;
      w_held <= 1'b0;
      wdata <= 32'h00000000;
      wstrb <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'h0;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= 2'h0;
      s_axi_rdata_o <= 32'h00000000;
      cs_meta <= 1'b0;
      cs_sync <= 1'b0;
      ext_cache_64k_o <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      wait_cfg <= next_wait_cfg;
      mem_cfg <= next_mem_cfg;
      aw_held <= next_aw_held;
      awaddr <= next_awaddr;
      w_held <= next_w_held;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      s_axi_awready_o <= !next_aw_held;
      s_axi_wready_o <= !next_w_held;
      s_axi_bvalid_o <= next_bvalid;
      s_axi_bresp_o <= next_bresp;
      s_axi_arready_o <= !next_rvalid;
      s_axi_rvalid_o <= next_rvalid;
      s_axi_rresp_o <= next_rresp;
      s_axi_rdata_o <= next_rdata;
      cs_meta <= cache_size_select_i;
      cs_sync <= cs_meta;
      ext_cache_64k_o <= next_ext64;
    end
  end

  // host access sequencer
  shadow_remap_pkg::acc_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic next_done, next_dram, next_cache, next_off_n;
  logic [23:0] next_daddr;
  logic take;

  assign take = acc_req_i && state == shadow_remap_pkg::ACC_IDLE;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_done = 1'b0;
    next_dram = dram_cyc_o;
    next_cache = cacheable_o;
    next_off_n = offboard_cycle_n_o;
    next_daddr = dram_addr_o;
    unique case (state)
      shadow_remap_pkg::ACC_IDLE: begin
        next_dram = 1'b0;
        next_cache = 1'b0;
        next_off_n = 1'b1;
        if (acc_req_i) begin
          next_state = shadow_remap_pkg::ACC_WAIT;
          next_cnt = wait_cfg;
          next_daddr = acc_addr_i;
          if (shadow_hit) begin
            next_dram = !acc_we_i || wr_en;
            next_cache = !acc_we_i;
            next_off_n = !(acc_we_i && !wr_en);
          end else if (in_remap) begin
            next_dram = 1'b1;
            next_cache = !acc_we_i;
            next_daddr = shadow_remap_pkg::REMAP_DRAM_BASE + roff[23:0];
          end else if (in_low) begin
            next_dram = 1'b1;
            next_cache = !acc_we_i;
          end else begin
            next_off_n = 1'b0;
          end
        end
      end
      shadow_remap_pkg::ACC_WAIT: begin
        if (cnt == 3'h0) begin
          next_done = 1'b1;
          next_state = shadow_remap_pkg::ACC_IDLE;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state <= shadow_remap_pkg::ACC_IDLE;
      cnt <= 3'h0;
      acc_busy_o <= 1'b0;
      acc_done_o <= 1'b0;
      dram_cyc_o <= 1'b0;
      cacheable_o <= 1'b0;
      offboard_cycle_n_o <= 1'b1;
      dram_addr_o <= 24'h000000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      acc_busy_o <= next_state == shadow_remap_pkg::ACC_WAIT;
      acc_done_o <= next_done;
      dram_cyc_o <= next_dram;
      cacheable_o <= next_cache;
      offboard_cycle_n_o <= next_off_n;
      dram_addr_o <= next_daddr;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_bios_read;
    take && !acc_we_i && shadow_en && layout[0] && acc_addr_i >= 24'h0E0000 &&
    acc_addr_i <= 24'h0FFFFF |=> dram_cyc_o && cacheable_o && dram_addr_o == $past(acc_addr_i);
  endproperty
  a_bios_read: assert property (p_bios_read) else $error("firmware shadow read missed");
  property p_vid128;
    take && !acc_we_i && shadow_en && layout == 2'h3 && acc_addr_i[23:16] == 8'h0D
    |=> dram_cyc_o && offboard_cycle_n_o;
  endproperty
  a_vid128: assert property (p_vid128) else $error("display shadow read missed");
  property p_no_vid;
    take && layout == 2'h0 && acc_addr_i[23:16] == 8'h0C |=> !dram_cyc_o && !offboard_cycle_n_o;
  endproperty
  a_no_vid: assert property (p_no_vid) else $error("display area shadowed in layout one");
  property p_locked;
    take && acc_we_i && !wr_en && shadow_hit |=> !dram_cyc_o && !offboard_cycle_n_o;
  endproperty
  a_locked: assert property (p_locked) else $error("locked shadow write reached DRAM");
  property p_init;
    take && acc_we_i && wr_en && shadow_hit |=> dram_cyc_o && offboard_cycle_n_o && !cacheable_o;
  endproperty
  a_init: assert property (p_init) else $error("shadow init write not to DRAM");
  property p_remap4m;
    take && !shadow_en && mem_cfg == 3'h3 && acc_addr_i == 24'h43FFFF
    |=> dram_cyc_o && dram_addr_o == 24'h0DFFFF;
  endproperty
  a_remap4m: assert property (p_remap4m) else $error("256K relocation wrong at 4M");
  property p_remap_none;
    take && shadow_en && layout == 2'h3 && mem_cfg == 3'h2 && acc_addr_i == 24'h200000
    |=> !dram_cyc_o;
  endproperty
  a_remap_none: assert property (p_remap_none) else $error("relocation with full shadow");
  property p_low;
    take && mem_cfg != 3'h0 && acc_addr_i < 24'h0A0000 |=> dram_cyc_o && offboard_cycle_n_o &&
    dram_addr_o == $past(acc_addr_i);
  endproperty
  a_low: assert property (p_low) else $error("base memory not decoded to DRAM");
  property p_wait3;
    take && wait_cfg == 3'h3 |=> !acc_done_o [*4] ##1 acc_done_o;
  endproperty
  a_wait3: assert property (p_wait3) else $error("wait state count wrong");
  property p_ext64;
    (EXT_CACHE && cache_size_select_i) [*3] |=> ext_cache_64k_o;
  endproperty
  a_ext64: assert property (p_ext64) else $error("64KB cache select not seen");
  property p_intcache;
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 5'h0C
    |=> s_axi_rvalid_o && s_axi_rdata_o[31:24] == 8'h80;
  endproperty
  a_intcache: assert property (p_intcache) else $error("internal cache size wrong");
  property p_busy;
    take |=> acc_busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("access busy flag missing");
  c_remap: cover property (take ##1 dram_cyc_o && dram_addr_o != $past(acc_addr_i));
  c_locked: cover property (take && acc_we_i && shadow_hit && !wr_en);
  c_wait: cover property (take && wait_cfg == 3'h7 ##[1:12] acc_done_o);
endmodule

//--- shared/shadow_remap_pkg.sv
// constants, register map and states for the shadow and remap memory decoder
package shadow_remap_pkg;
  localparam int AW = 5;
  localparam logic [AW-1:0] OFS_CTRL = 5'h00;
  localparam logic [AW-1:0] OFS_WAIT = 5'h04;
  localparam logic [AW-1:0] OFS_MEM = 5'h08;
  localparam logic [AW-1:0] OFS_STAT = 5'h0C;
  localparam int CTRL_LAYOUT_LSB = 0;
  localparam int CTRL_SHADOW_EN = 2;
  localparam int CTRL_WR_EN = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] WAIT_RST = 3'h0;
  localparam logic [2:0] MEM_RST = 3'h0;
  localparam int STAT_MEM_LSB = 0;
  localparam int STAT_REMAP_LSB = 8;
  localparam int STAT_EXT_LSB = 16;
  localparam int STAT_INT_LSB = 24;
  localparam logic [23:0] UMA_BASE = 24'h0A0000;
  localparam logic [23:0] VID_BASE = 24'h0C0000;
  localparam logic [23:0] VID64_END = 24'h0D0000;
  localparam logic [23:0] BIOS128_BASE = 24'h0E0000;
  localparam logic [23:0] BIOS64_BASE = 24'h0F0000;
  localparam logic [23:0] MB1 = 24'h100000;
  localparam logic [24:0] MB16 = 25'h1000000;
  localparam logic [23:0] REMAP_DRAM_BASE = 24'h0A0000;
  localparam logic [3:0] UNITS_384K = 4'h6;
  localparam logic [3:0] UNITS_256K = 4'h4;
  localparam logic [7:0] INT_CACHE_BYTES = 8'h80;
  localparam logic [6:0] EXT_KB_32 = 7'h20;
  localparam logic [6:0] EXT_KB_64 = 7'h40;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ACC_IDLE, ACC_WAIT} acc_state_t;
endpackage

//--- tb/host_bus_model.sv
// host bus partner: issues single memory accesses and collects the decode result
`timescale 1ns/10ps
module host_bus_model (
  input wire logic clk_i, // system clock
  input wire logic done_i, // access finished pulse
  input wire logic dram_i, // access goes to DRAM
  input wire logic [23:0] daddr_i, // DRAM address after relocation
  input wire logic cache_i, // read may be cached
  input wire logic offn_i, // off-board cycle, active low
  output logic req_o, // access request
  output logic [23:0] addr_o, // byte address
  output logic we_o // access is a write
);
  initial begin
    req_o = 1'h0;
    addr_o = 24'h000000;
    we_o = 1'h0;
  end
  // request lasts one edge; address and direction are inverted after the take
  // so that a design reading them late sees garbage, not a held value
  task automatic access(input logic [23:0] a, input logic w, output logic [26:0] res,
                        output int lat);
    @(posedge clk_i);
    req_o <= 1'h1;
    addr_o <= a;
    we_o <= w;
    @(posedge clk_i);
    req_o <= 1'h0;
    addr_o <= ~a;
    we_o <= ~w;
    lat = 0;
    do begin
      @(posedge clk_i);
      lat++;
    end while (done_i !== 1'h1 && lat < 64);
    res = {dram_i, daddr_i, cache_i, offn_i};
  endtask
endmodule

//--- tb/shadow_remap_memory_decoder_tb.sv
// self-checking bench for the shadow and remap memory decoder
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module shadow_remap_memory_decoder_tb;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [2:0] mem;
    logic [23:0] addr;
    logic we;
    logic [26:0] exp;
  } row_t;
  logic clk_sys_i, resetn_i, sel;
  logic [4:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, done, dram, cache, offn, ext64;
  logic [1:0] bresp, rresp, rsp;
  logic [23:0] daddr, haddr;
  logic hreq, hwe;
  logic [26:0] got;
  int lat, err_count, total_checks, cyc;
  row_t rows [19];
  logic [4:0] mb [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0C, 5'h10};
  logic [3:0] uoff [8] = '{4'h0, 4'h6, 4'h6, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0};

  shadow_remap_memory_decoder #(.EXT_CACHE(1'h1)) shadow_remap_memory_decoder_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .acc_req_i(hreq),
    .acc_addr_i(haddr), .acc_we_i(hwe), .acc_busy_o(), .acc_done_o(done),
    .dram_cyc_o(dram), .dram_addr_o(daddr), .cacheable_o(cache),
    .offboard_cycle_n_o(offn), .cache_size_select_i(sel), .ext_cache_64k_o(ext64));

  host_bus_model host_bus_model_i (.clk_i(clk_sys_i), .done_i(done), .dram_i(dram),
    .daddr_i(daddr), .cache_i(cache), .offn_i(offn), .req_o(hreq), .addr_o(haddr),
    .we_o(hwe));

  initial begin
    clk_sys_i = 1'h0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_open;
    logic w_open;
    @(posedge clk_sys_i);
    aw_open = 1'h1;
    w_open = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (aw_open || w_open) begin
      @(posedge clk_sys_i);
      if (aw_open && awready === 1'h1) begin
        aw_open = 1'h0;
        awvalid <= 1'h0;
      end
      if (w_open && wready === 1'h1) begin
        w_open = 1'h0;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clk_sys_i); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk_sys_i); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk_sys_i); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  initial begin
    rows = '{
      '{4'h0, 3'h1, 24'h100010, 1'h0, {1'h1, 24'h0A0010, 1'h1, 1'h1}},
      '{4'h0, 3'h1, 24'h160000, 1'h0, {1'h0, 24'h160000, 1'h0, 1'h0}},
      '{4'h0, 3'h3, 24'h43FFFF, 1'h0, {1'h1, 24'h0DFFFF, 1'h1, 1'h1}},
      '{4'h0, 3'h3, 24'h440000, 1'h0, {1'h0, 24'h440000, 1'h0, 1'h0}},
      '{4'h0, 3'h4, 24'h500000, 1'h0, {1'h0, 24'h500000, 1'h0, 1'h0}},
      '{4'h4, 3'h5, 24'h0F0000, 1'h0, {1'h1, 24'h0F0000, 1'h1, 1'h1}},
      '{4'h4, 3'h5, 24'h0EFFFC, 1'h0, {1'h0, 24'h0EFFFC, 1'h0, 1'h0}},
      '{4'h5, 3'h5, 24'h0E0000, 1'h0, {1'h1, 24'h0E0000, 1'h1, 1'h1}},
      '{4'h6, 3'h5, 24'h0C0000, 1'h0, {1'h1, 24'h0C0000, 1'h1, 1'h1}},
      '{4'h6, 3'h5, 24'h0D0000, 1'h0, {1'h0, 24'h0D0000, 1'h0, 1'h0}},
      '{4'h7, 3'h5, 24'h0DFFFC, 1'h0, {1'h1, 24'h0DFFFC, 1'h1, 1'h1}},
      '{4'h4, 3'h5, 24'h800000, 1'h0, {1'h1, 24'h0A0000, 1'h1, 1'h1}},
      '{4'h7, 3'h5, 24'h800000, 1'h0, {1'h0, 24'h800000, 1'h0, 1'h0}},
      '{4'hC, 3'h5, 24'h0F0000, 1'h1, {1'h1, 24'h0F0000, 1'h0, 1'h1}},
      '{4'h4, 3'h5, 24'h0F0000, 1'h1, {1'h0, 24'h0F0000, 1'h0, 1'h0}},
      '{4'h4, 3'h5, 24'h100000, 1'h1, {1'h1, 24'h100000, 1'h0, 1'h1}},
      '{4'h3, 3'h7, 24'h0F0000, 1'h0, {1'h0, 24'h0F0000, 1'h0, 1'h0}},
      '{4'h4, 3'h5, 24'h0C0000, 1'h0, {1'h0, 24'h0C0000, 1'h0, 1'h0}},
      '{4'h7, 3'h2, 24'h200000, 1'h0, {1'h0, 24'h200000, 1'h0, 1'h0}}};
    {resetn_i, sel, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata} = 42'h0;
    repeat (16) @(posedge clk_sys_i);
    resetn_i <= 1'h1;
    repeat (2) @(posedge clk_sys_i);
    for (int i = 0; i < 3; i++) begin
      axi_rd(5'(4 * i), rd, rsp);
      `CHK("reset_reg", 32'h0, rd)
    end
    `CHK("ext64_off", 1'h0, ext64)
    foreach (rows[k]) begin
      axi_wr(shadow_remap_pkg::OFS_MEM, {29'h0, rows[k].mem}, rsp);
      axi_wr(shadow_remap_pkg::OFS_CTRL, {28'h0, rows[k].ctrl}, rsp);
      host_bus_model_i.access(rows[k].addr, rows[k].we, got, lat);
      `CHK("decode", rows[k].exp, got)
    end
    axi_wr(shadow_remap_pkg::OFS_CTRL, 32'h0, rsp);
    for (int m = 0; m < 8; m++) begin
      axi_wr(shadow_remap_pkg::OFS_MEM, 32'(m), rsp);
      axi_rd(shadow_remap_pkg::OFS_STAT, rd, rsp);
      `CHK("stat_off", {8'h80, 1'h0, 7'h20, 4'h0, uoff[m], 3'h0, mb[m]}, rd)
    end
    for (int l = 0; l < 4; l++) begin
      axi_wr(shadow_remap_pkg::OFS_CTRL, 32'(4 + l), rsp);
      axi_rd(shadow_remap_pkg::OFS_STAT, rd, rsp);
      `CHK("stat_on", (l == 3) ? 4'h0 : 4'h4, rd[11:8])
    end
    axi_wr(shadow_remap_pkg::OFS_CTRL, 32'h0, rsp);
    for (int w = 0; w < 8; w++) begin
      axi_wr(shadow_remap_pkg::OFS_WAIT, 32'(w), rsp);
      host_bus_model_i.access(24'h000100, 1'h0, got, lat);
      `CHK("latency", w + 2, lat)
    end
    axi_rd(5'h10, rd, rsp);
    `CHK("unmapped_rd", {2'h2, 32'h0}, {rsp, rd})
    axi_wr(5'h14, 32'h0, rsp);
    `CHK("unmapped_wr", 2'h2, rsp)
    axi_wr(shadow_remap_pkg::OFS_STAT, 32'h0, rsp);
    `CHK("stat_wr", 2'h0, rsp)
    sel <= 1'h1;
    repeat (4) @(posedge clk_sys_i);
    `CHK("ext64_on", 1'h1, ext64)
    axi_rd(shadow_remap_pkg::OFS_STAT, rd, rsp);
    `CHK("stat_ext", {8'h80, 1'h0, 7'h40}, rd[31:16])
    axi_wr(shadow_remap_pkg::OFS_CTRL, 32'hF, rsp);
    resetn_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'h1;
    repeat (2) @(posedge clk_sys_i);
    axi_rd(shadow_remap_pkg::OFS_CTRL, rd, rsp);
    `CHK("ctrl_rst", 32'h0, rd)
    `CHK("offn_idle", 1'h1, offn)
    report_and_stop();
  end
endmodule
